// ### core/ccel_pkg.sv
// shared constants for the comparator control and event logic
`default_nettype none

package ccel_pkg;

    // ==========================================================
    // geometry
    localparam int NCH = 4;
    localparam int NAMP = 3;
    localparam int REG_W = 16;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // register byte offsets on the bus
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CTL_BASE = 12'h004;
    localparam logic [11:0] OFS_CTL_STEP = 12'h004;

    // ==========================================================
    // control word fields
    localparam int BIT_EN = 15;
    localparam int BIT_OE = 14;
    localparam int BIT_POL = 13;
    localparam int BIT_AMP = 10;
    localparam int BIT_EVT = 9;
    localparam int BIT_RES = 8;
    localparam int BIT_EDGE_LO = 6;
    localparam int BIT_REF = 4;
    localparam int BIT_NEG_LO = 0;

    // ==========================================================
    // status word fields
    localparam int BIT_STOP_IDLE = 15;
    localparam int STAT_EVT_LO = 8;
    localparam int STAT_RES_LO = 0;

    // ==========================================================
    // writable bits and reset values
    localparam logic [15:0] CTL_WMASK = 16'he4d3;
    localparam logic [15:0] CTL4_WMASK = 16'he0d3;
    localparam logic [15:0] CTL_RST = 16'h0000;
    localparam logic STOP_IDLE_RST = 1'b0;

    // ==========================================================
    // event edge codes
    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_ANY = 2'h3
    } ccel_edge_e;

endpackage : ccel_pkg

`default_nettype wire

// ### core/ccel_chan.sv
// one channel: result synchroniser, polarity, edge detect, sticky event
`default_nettype none

module ccel_chan (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw_in,
    input wire logic run,
    input wire logic polarity,
    input wire ccel_pkg::ccel_edge_e edge_sel,
    input wire logic evt_wr,
    input wire logic evt_wdata,
    output logic result,
    output logic event_flag,
    output logic trigger
);
    import ccel_pkg::*;

    logic sync1_ff;
    logic sync2_ff;
    logic res_ff;
    logic evt_ff;
    logic trig_ff;
    logic nxt_res;
    logic nxt_evt;
    logic rise;
    logic fall;
    logic hit;
    logic set;

    // ==========================================================
    // next state
    always_comb begin
        nxt_res = run ? (sync2_ff ^ polarity) : 1'b0;
        rise = run && !res_ff && nxt_res;
        fall = run && res_ff && !nxt_res;
        unique case (edge_sel)
            EDGE_OFF: hit = 1'b0;
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_ANY: hit = rise || fall;
        endcase
        set = hit && !evt_ff;
        nxt_evt = set || (evt_wr ? evt_wdata : evt_ff);
    end

    // ==========================================================
    // registers
    // two-stage sync, one prior sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            res_ff <= 1'b0;
            evt_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            res_ff <= nxt_res;
            evt_ff <= nxt_evt;
            trig_ff <= set;
        end
    end

    assign result = res_ff;
    assign event_flag = evt_ff;
    assign trigger = trig_ff;

endmodule // ccel_chan

`default_nettype wire

// ### core/ccel_top.sv
// comparator control, status and event logic behind an apb slave
`default_nettype none

module ccel_top #(
    parameter logic [3:0] POS_BONDED = 4'hf,
    parameter logic [15:0] NEG_BONDED = 16'hf333
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic idle_mode,
    input wire logic [ccel_pkg::NCH-1:0] cmp_raw,
    output logic [ccel_pkg::NCH-1:0] compare_output_pin,
    output logic [ccel_pkg::NCH-1:0] compare_output_pin_oe,
    output logic [ccel_pkg::NCH-1:0] chan_power,
    output logic [ccel_pkg::NAMP-1:0] amp_mode,
    output logic [ccel_pkg::NCH-1:0] pos_use_ref,
    output logic [2*ccel_pkg::NCH-1:0] neg_sel,
    output logic [ccel_pkg::NCH-1:0] pos_tie_gnd,
    output logic [ccel_pkg::NCH-1:0] neg_tie_gnd,
    output logic [ccel_pkg::NCH-1:0] event_trigger
);
    import ccel_pkg::*;

    // ==========================================================
    // address decode: 0 status, 1..4 control, 7 unmapped
    function automatic logic [2:0] reg_index(input logic [11:0] a);
        logic [2:0] idx;
        idx = 3'h7;
        if (a == OFS_STATUS) begin
            idx = 3'h0;
        end
        for (int k = 0; k < NCH; k++) begin
            if (a == OFS_CTL_BASE + 12'(k) * OFS_CTL_STEP) begin
                idx = 3'(k + 1);
            end
        end
        return idx;
    endfunction

    logic [15:0] ctl_ff [NCH];
    logic [15:0] nxt_ctl [NCH];
    logic stop_idle_ff;
    logic nxt_stop_idle;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [NCH-1:0] pin_ff;
    logic [NCH-1:0] nxt_pin;
    logic [NCH-1:0] pin_oe_ff;
    logic [NCH-1:0] nxt_pin_oe;
    logic [NCH-1:0] power_ff;
    logic [NCH-1:0] nxt_power;
    logic [NAMP-1:0] amp_ff;
    logic [NAMP-1:0] nxt_amp;
    logic [NCH-1:0] ref_ff;
    logic [NCH-1:0] nxt_ref;
    logic [2*NCH-1:0] neg_ff;
    logic [2*NCH-1:0] nxt_neg;
    logic [NCH-1:0] pos_gnd_ff;
    logic [NCH-1:0] nxt_pos_gnd;
    logic [NCH-1:0] neg_gnd_ff;
    logic [NCH-1:0] nxt_neg_gnd;
    logic [2:0] idx;
    logic access;
    logic done;
    logic wr_go;
    logic [15:0] wmask;
    logic [15:0] status_w;
    logic [NCH-1:0] amp_w;
    logic [NCH-1:0] run_w;
    logic [NCH-1:0] evt_w;
    logic [NCH-1:0] res_w;
    logic [NCH-1:0] trig_w;
    logic [NCH-1:0] evt_wr_w;

    // ==========================================================
    // bus handshake: one wait state, answer registered
    always_comb begin
        idx = reg_index(paddr);
        access = psel && penable;
        done = access && pready_ff;
        wr_go = done && pwrite && (idx != 3'h7);
        wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        nxt_pready = access && !pready_ff;
        nxt_pslverr = nxt_pready && (idx == 3'h7);
        nxt_prdata = 32'h0000_0000;
        if (nxt_pready && !pwrite) begin
            if (idx == 3'h0) begin
                nxt_prdata = {16'h0000, status_w};
            end else if (idx != 3'h7) begin
                nxt_prdata = {16'h0000, ctl_rd(idx - 3'h1)};
            end
        end
    end

    // ==========================================================
    // readback
    function automatic logic [15:0] ctl_rd(input logic [2:0] i);
        logic [15:0] v;
        v = 16'h0000;
        for (int k = 0; k < NCH; k++) begin
            if (3'(k) == i) begin
                v = ctl_ff[k];
                v[BIT_EVT] = evt_w[k];
                v[BIT_RES] = res_w[k];
            end
        end
        return v;
    endfunction

    always_comb begin
        status_w = 16'h0000;
        status_w[BIT_STOP_IDLE] = stop_idle_ff;
        status_w[STAT_EVT_LO +: NCH] = evt_w;
        status_w[STAT_RES_LO +: NCH] = res_w;
    end

    // ==========================================================
    // register writes
    always_comb begin
        nxt_stop_idle = stop_idle_ff;
        if (wr_go && idx == 3'h0 && pstrb[1]) begin
            nxt_stop_idle = pwdata[BIT_STOP_IDLE];
        end
        for (int k = 0; k < NCH; k++) begin
            nxt_ctl[k] = ctl_ff[k];
            evt_wr_w[k] = wr_go && (idx == 3'(k + 1)) && pstrb[1];
            if (wr_go && idx == 3'(k + 1)) begin
                nxt_ctl[k] = (ctl_ff[k] & ~wmask) | (pwdata[15:0] & wmask &
                    ((k == NCH - 1) ? CTL4_WMASK : CTL_WMASK));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NCH; k++) begin
                ctl_ff[k] <= CTL_RST;
            end
            stop_idle_ff <= STOP_IDLE_RST;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            for (int k = 0; k < NCH; k++) begin
                ctl_ff[k] <= nxt_ctl[k];
            end
            stop_idle_ff <= nxt_stop_idle;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // ==========================================================
    // channels
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        // mode bit only on amplifier-capable channels
        assign amp_w[g] = (g < NAMP) && ctl_ff[g][BIT_AMP];
        assign run_w[g] = ctl_ff[g][BIT_EN] && !amp_w[g] &&
            !(stop_idle_ff && idle_mode);
        ccel_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .raw_in(cmp_raw[g]),
            .run(run_w[g]),
            .polarity(ctl_ff[g][BIT_POL]),
            .edge_sel(ccel_edge_e'(ctl_ff[g][BIT_EDGE_LO +: 2])),
            .evt_wr(evt_wr_w[g]),
            .evt_wdata(pwdata[BIT_EVT]),
            .result(res_w[g]),
            .event_flag(evt_w[g]),
            .trigger(trig_w[g])
        );
    end

    // ==========================================================
    // analog steering and pin
    always_comb begin
        nxt_amp = amp_w[NAMP-1:0];
        for (int k = 0; k < NCH; k++) begin
            nxt_power[k] = ctl_ff[k][BIT_EN] && !(stop_idle_ff && idle_mode);
            nxt_pin_oe[k] = run_w[k] && ctl_ff[k][BIT_OE];
            nxt_pin[k] = nxt_pin_oe[k] && res_w[k];
            nxt_ref[k] = ctl_ff[k][BIT_REF] && !amp_w[k];
            // two minus pins on amp channels
            // four minus sources on channel four
            nxt_neg[2*k +: 2] = ctl_ff[k][BIT_NEG_LO +: 2];
            nxt_pos_gnd[k] = !nxt_ref[k] && !POS_BONDED[k];
            nxt_neg_gnd[k] = !NEG_BONDED[4*k + int'(ctl_ff[k][BIT_NEG_LO +: 2])];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= '0;
            pin_oe_ff <= '0;
            power_ff <= '0;
            amp_ff <= '0;
            ref_ff <= '0;
            neg_ff <= '0;
            pos_gnd_ff <= '0;
            neg_gnd_ff <= '0;
        end else begin
            pin_ff <= nxt_pin;
            pin_oe_ff <= nxt_pin_oe;
            power_ff <= nxt_power;
            amp_ff <= nxt_amp;
            ref_ff <= nxt_ref;
            neg_ff <= nxt_neg;
            pos_gnd_ff <= nxt_pos_gnd;
            neg_gnd_ff <= nxt_neg_gnd;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign compare_output_pin = pin_ff;
    assign compare_output_pin_oe = pin_oe_ff;
    assign chan_power = power_ff;
    assign amp_mode = amp_ff;
    assign pos_use_ref = ref_ff;
    assign neg_sel = neg_ff;
    assign pos_tie_gnd = pos_gnd_ff;
    assign neg_tie_gnd = neg_gnd_ff;
    // triggers come straight from channel flip-flops
    assign event_trigger = trig_w;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    idle_stop_halts_a: assert property (
        (stop_idle_ff && idle_mode) |=> (event_trigger == '0))
        else $error("trigger while stopped in idle");

    evt_mirror_rd_a: assert property (
        (done && !pwrite && paddr == OFS_STATUS) |->
            (prdata[11:8] == $past(evt_w)))
        else $error("status event bits differ from flags");

    res_mirror_rd_a: assert property (
        (done && !pwrite && paddr == OFS_STATUS) |->
            (prdata[3:0] == $past(res_w)))
        else $error("status result bits differ from results");

    disabled_no_trig_a: assert property (
        (event_trigger & $past(~run_w)) == '0)
        else $error("trigger from halted channel");

    pin_gated_a: assert property (
        !ctl_ff[0][BIT_OE] |=> !compare_output_pin[0] && !compare_output_pin_oe[0])
        else $error("pin driven with output disabled");

    amp_blocks_pin_a: assert property (
        ctl_ff[1][BIT_AMP] |=> !pos_use_ref[1] && !compare_output_pin_oe[1])
        else $error("pin or reference live in amplifier mode");

    sticky_blocks_a: assert property (
        (event_trigger & $past(evt_w)) == '0)
        else $error("trigger while event flag set");

    edge_off_quiet_a: assert property (
        (ctl_ff[0][7:6] == 2'h0) |=> !event_trigger[0])
        else $error("trigger with edge select off");

    rise_edge_a: assert property (
        (event_trigger[0] && $past(ctl_ff[0][7:6]) == 2'h1) |->
            (res_w[0] && !$past(res_w[0])))
        else $error("rising code fired without rise");

    fall_edge_a: assert property (
        (event_trigger[0] && $past(ctl_ff[0][7:6]) == 2'h2) |->
            (!res_w[0] && $past(res_w[0])))
        else $error("falling code fired without fall");

    neg_route_a: assert property (
        neg_sel[7:6] == $past(ctl_ff[3][1:0]))
        else $error("channel four minus select not routed");

    trig_sets_flag_a: assert property (
        event_trigger[0] |-> evt_w[0] && (res_w[0] != $past(res_w[0])))
        else $error("trigger without result change");

    unimpl_zero_a: assert property (
        (done && !pwrite) |-> (prdata[31:16] == 16'h0000))
        else $error("upper data bits not zero");

    trig_cov_c: cover property (event_trigger[0] ##[1:40] !evt_w[0]);
    idle_cov_c: cover property (stop_idle_ff && idle_mode && ctl_ff[1][BIT_EN]);
    err_cov_c: cover property (done && pslverr);
    fall_cov_c: cover property (event_trigger[0] && ctl_ff[0][7:6] == 2'h2);

endmodule // ccel_top

`default_nettype wire

// ### verif/ccel_cmp_model.sv
// behavioural analog comparator cores feeding the raw outputs
`default_nettype none

module ccel_cmp_model (
    input wire logic [3:0] plus_gt_minus,
    input wire logic [3:0] chan_power,
    input wire logic [3:0] amp_on,
    output wire logic [3:0] cmp_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // unpowered or amplifier cores give a meaningless, moving level
    logic wobble = 1'b0;
    always #3 wobble = ~wobble;

    for (genvar i = 0; i < 4; i++) begin : g_core
        logic q = 1'b0;
        // output high when plus above minus
        always @(plus_gt_minus[i], chan_power[i], amp_on[i], wobble) begin
            q <= #(i + 1) (chan_power[i] && !amp_on[i]) ? plus_gt_minus[i] : (wobble ^ (i % 2 == 1));
        end
        assign cmp_raw[i] = q;
    end
endmodule // ccel_cmp_model

`default_nettype wire

// ### verif/test_ccel_top.sv
// self-checking bench for the comparator control and event logic
`default_nettype none

module test_ccel_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccel_pkg::*;

    localparam logic [3:0] POS_B = 4'hb;
    localparam logic [15:0] NEG_B = 16'hf333;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic idle_mode = 1'b0;
    logic [3:0] lvl = '0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] cmp_raw, pin, pin_oe, chan_power, use_ref, pos_gnd, neg_gnd, trig;
    wire [2:0] amp_mode;
    wire [7:0] neg_sel;
    int fails = 0;
    int tests_run = 0;
    int seed = 54;
    int trig_cnt[4] = '{0, 0, 0, 0};

    ccel_top #(.POS_BONDED(POS_B), .NEG_BONDED(NEG_B)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_mode(idle_mode), .cmp_raw(cmp_raw), .compare_output_pin(pin),
        .compare_output_pin_oe(pin_oe), .chan_power(chan_power), .amp_mode(amp_mode),
        .pos_use_ref(use_ref), .neg_sel(neg_sel), .pos_tie_gnd(pos_gnd), .neg_tie_gnd(neg_gnd),
        .event_trigger(trig)
    );

    ccel_cmp_model cores (
        .plus_gt_minus(lvl), .chan_power(chan_power), .amp_on({1'b0, amp_mode}), .cmp_raw(cmp_raw)
    );

    initial begin
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) trig_cnt[i] <= trig_cnt[i] + ((trig[i] === 1'b1) ? 1 : 0);
    end

    // ==========================================================
    // reporting
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        chk_word({28'h0, got}, {28'h0, exp});
    endtask

    // ==========================================================
    // apb master
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 16'h0000, r, e);
        chk_word(r & msk, exp);
    endtask

    function automatic logic [11:0] ca(input int ch);
        return OFS_CTL_BASE + OFS_CTL_STEP * 12'(ch);
    endfunction

    function automatic logic fires(input logic [1:0] code, input logic adj);
        return code == 2'h3 || (code == 2'h1 && adj) || (code == 2'h2 && !adj);
    endfunction

    // ==========================================================
    // one edge scenario: arm, toggle, toggle back, second toggle triggers only if the first did not
    task automatic edge_case(input int ch, input logic [1:0] code, input logic pol);
        logic start, adj, f1, f2;
        logic [15:0] cw;
        int n0;
        start = 1'($random(seed));
        cw = 16'hc000 | (16'(pol) << BIT_POL);
        lvl[ch] <= start;
        wr(ca(ch), cw);
        repeat (10) @(posedge pclk);
        cw = cw | (16'(code) << BIT_EDGE_LO);
        wr(ca(ch), cw);
        n0 = trig_cnt[ch];
        lvl[ch] <= ~start;
        repeat (10) @(posedge pclk);
        adj = ~start ^ pol;
        f1 = fires(code, adj);
        chk_word(trig_cnt[ch] - n0, 32'(f1));
        chk_pin({2'b00, pin_oe[ch], pin[ch]}, {3'b001, adj});
        rd_chk(ca(ch), 32'(cw | (16'(f1) << BIT_EVT) | (16'(adj) << BIT_RES)), 32'hffff);
        rd_chk(OFS_STATUS, (32'(f1) << (8 + ch)) | (32'(adj) << ch), 32'hffff);
        n0 = trig_cnt[ch];
        lvl[ch] <= start;
        repeat (10) @(posedge pclk);
        f2 = !f1 && fires(code, ~adj);
        chk_word(trig_cnt[ch] - n0, 32'(f2));
        wr(ca(ch), 16'h0000);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [15:0] msk;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFS_STATUS, 32'h0, 32'hffffffff);
        for (int ch = 0; ch < 4; ch++) begin
            rd_chk(ca(ch), 32'h0, 32'hffffffff);
            wr(ca(ch), 16'hffff);
            msk = (ch == 3) ? CTL4_WMASK : CTL_WMASK;
            rd_chk(ca(ch), {16'h0, msk} | 32'h0200, 32'hfffffeff);
        end
        repeat (3) @(posedge pclk);
        chk_pin({1'b0, amp_mode}, 4'h7);
        chk_pin(pin_oe, 4'h8);
        chk_pin(use_ref, 4'h8);
        wr(OFS_STATUS, 16'hffff);
        rd_chk(OFS_STATUS, 32'h8f00, 32'hfffffff0);
        apb(1'b0, 12'h014, 16'h0000, r, e);
        chk_word({e, r[30:0]}, 32'h80000000);
        for (int ch = 0; ch < 4; ch++) wr(ca(ch), 16'h0000);
        // idle stop and enable combinations on channel two
        for (int k = 0; k < 8; k++) begin
            idle_mode <= k[2];
            wr(OFS_STATUS, 16'(k[1]) << BIT_STOP_IDLE);
            wr(ca(1), 16'(k[0]) << BIT_EN);
            repeat (3) @(posedge pclk);
            chk_pin(chan_power, {2'b00, k[0] && !(k[1] && k[2]), 1'b0});
        end
        idle_mode <= 1'b0;
        wr(OFS_STATUS, 16'h0000);
        wr(ca(1), 16'h0000);
        // input selection and unbonded ties
        for (int ch = 0; ch < 4; ch++) begin
            for (int c = 0; c < 4; c++) begin
                wr(ca(ch), 16'h8000 | 16'(c));
                repeat (2) @(posedge pclk);
                chk_word({30'h0, neg_sel[2 * ch +: 2]}, 32'(c));
                chk_pin({neg_gnd[ch], pos_gnd[ch], use_ref[ch], 1'b0},
                        {!NEG_B[4 * ch + c], !POS_B[ch], 2'b00});
            end
            wr(ca(ch), 16'h8010);
            repeat (2) @(posedge pclk);
            chk_pin({2'b00, pos_gnd[ch], use_ref[ch]}, 4'h1);
            wr(ca(ch), 16'h0000);
        end
        // every edge code under both polarities, random channel
        for (int k = 0; k < 16; k++) edge_case(($random(seed) & 3), 2'(k), k[2]);
        give_verdict();
    end
endmodule // test_ccel_top

`default_nettype wire
